// ===== design/io_select_pkg.sv
// package with address windows and field positions for the chip-select decoder
package io_select_pkg;

  // address bus width of the host
  localparam int          ADDR_W         = 16;
  // number of chip-enable outputs
  localparam int          NUM_SEL        = 8;
  // io area base address (512 bytes, aligned)
  localparam logic [15:0] IO_BASE        = 16'hFA00;
  // io area size in address bits: 8 windows of 64 bytes
  localparam int          AREA_BITS      = 9;
  // window size in address bits
  localparam int          WIN_BITS       = 6;
  // field position of the window index inside the area offset
  localparam int          IDX_LSB        = WIN_BITS;
  localparam int          IDX_MSB        = AREA_BITS - 1;
  // window offsets from base, one per chip enable
  localparam logic [8:0]  WIN_CLOCK_OFS  = 9'h000;
  localparam logic [8:0]  WIN_CAN_OFS    = 9'h040;
  localparam logic [8:0]  WIN_DISP_OFS   = 9'h080;
  localparam logic [8:0]  WIN_USER4_OFS  = 9'h0C0;
  localparam logic [8:0]  WIN_USER5_OFS  = 9'h100;
  localparam logic [8:0]  WIN_USER6_OFS  = 9'h140;
  localparam logic [8:0]  WIN_USER7_OFS  = 9'h180;
  localparam logic [8:0]  WIN_USER8_OFS  = 9'h1C0;
  // reset value of the select outputs, all idle high
  localparam logic [7:0]  SEL_IDLE       = 8'hFF;

  // host bus sample carried into the decoder
  typedef struct packed {
    logic [15:0] addr;
    logic        rd_n;
    logic        wr_n;
  } host_bus_t;

  // decoder state
  typedef enum logic [0:0] {
    DEC_IDLE   = 1'b0,
    DEC_ACTIVE = 1'b1
  } dec_state_t;

endpackage

// ===== design/io_window_chip_select_decoder.sv
// chip-select decoder for the eight 64-byte io windows
// Function
// - eight active-low selects, 64-byte windows each
// - select one covers base+00H..3FH, clock
// - select two covers base+40H..7FH, can
// - select three covers base+80H..BFH, display
// - select four covers base+C0H..FFH, user
// - selects five..eight cover 100H..1FFH
// - default decode uses address lines only
// - option adds read/write strobe qualification
// - strobe qualification off unless selected
`timescale 1ns/1ps
module io_window_chip_select_decoder
  import io_select_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // host bus
  input  wire logic [15:0] ADDR_IN,
  input  wire logic        RD_N_IN,
  input  wire logic        WR_N_IN,
  // board option, high selects strobe qualification
  input  wire logic        STROBE_QUALIFY_OPTION_IN,
  // chip selects, active low
  output logic             CLOCK_CHIP_SELECT_N_OUT,
  output logic             CAN_CHIP_SELECT_N_OUT,
  output logic             DISPLAY_CHIP_SELECT_N_OUT,
  output logic             USER_SELECT4_N_OUT,
  output logic             USER_SELECT5_N_OUT,
  output logic             USER_SELECT6_N_OUT,
  output logic             USER_SELECT7_N_OUT,
  output logic             USER_SELECT8_N_OUT,
  // decoder busy flag
  output logic             SELECT_ACTIVE_OUT
);

  // ****************************************
  // address decode
  // ****************************************

  localparam logic [8:0] WIN_OFS_TABLE [NUM_SEL] = '{
    WIN_CLOCK_OFS, WIN_CAN_OFS, WIN_DISP_OFS, WIN_USER4_OFS,
    WIN_USER5_OFS, WIN_USER6_OFS, WIN_USER7_OFS, WIN_USER8_OFS
  };

  host_bus_t            bus;
  logic                 in_area;
  logic [8:0]           area_ofs;
  logic [NUM_SEL-1:0]   hit;
  logic                 strobe_ok;
  logic [NUM_SEL-1:0]   sel_n_next;
  logic [NUM_SEL-1:0]   sel_n_reg;
  dec_state_t           state_next;
  dec_state_t           state_reg;

  // bundle the bus pins
  assign bus.addr = ADDR_IN;
  assign bus.rd_n = RD_N_IN;
  assign bus.wr_n = WR_N_IN;

  // area check first
  // upper bits must match the base, else no select
  assign in_area  = (bus.addr[ADDR_W-1:AREA_BITS] == IO_BASE[ADDR_W-1:AREA_BITS]);
  assign area_ofs = bus.addr[AREA_BITS-1:0];

  // one window comparator per table entry
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEL; gi++)
    begin : g_win
      window_match #(
        .WIN_OFS (WIN_OFS_TABLE[gi])
      ) u_match (
        .in_area_in  (in_area),
        .area_ofs_in (area_ofs),
        .hit_out     (hit[gi])
      );
    end
  endgenerate

  // ****************************************
  // strobe qualification and output registers
  // ****************************************

  // option high needs read or write strobe, glitch free
  assign strobe_ok = !STROBE_QUALIFY_OPTION_IN || !bus.rd_n || !bus.wr_n;

  // next select values; windows disjoint so at most one bit low
  always_comb
  begin
    sel_n_next = SEL_IDLE;
    state_next = DEC_IDLE;
    if (strobe_ok && (hit != '0))
    begin
      sel_n_next = ~hit;
      state_next = DEC_ACTIVE;
    end
  end

  // registered outputs cost one cycle but remove decode glitches at the pins
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sel_n_reg <= SEL_IDLE;
      state_reg <= DEC_IDLE;
    end
    else
    begin
      sel_n_reg <= sel_n_next;
      state_reg <= state_next;
    end
  end

  // output mapping
  assign CLOCK_CHIP_SELECT_N_OUT   = sel_n_reg[0];
  assign CAN_CHIP_SELECT_N_OUT     = sel_n_reg[1];
  assign DISPLAY_CHIP_SELECT_N_OUT = sel_n_reg[2];
  assign USER_SELECT4_N_OUT        = sel_n_reg[3];
  assign USER_SELECT5_N_OUT        = sel_n_reg[4];
  assign USER_SELECT6_N_OUT        = sel_n_reg[5];
  assign USER_SELECT7_N_OUT        = sel_n_reg[6];
  assign USER_SELECT8_N_OUT        = sel_n_reg[7];
  assign SELECT_ACTIVE_OUT         = (state_reg == DEC_ACTIVE);

endmodule

// ===== design/window_match.sv
// one address window comparator of the chip-select decoder
`timescale 1ns/1ps
module window_match
  import io_select_pkg::*;
#(
  parameter logic [8:0] WIN_OFS = 9'h000
)
(
  // area offset and hit
  input  wire logic        in_area_in,
  input  wire logic [8:0]  area_ofs_in,
  output logic             hit_out
);

  // compare only the window index field; low bits select inside the window
  assign hit_out = in_area_in && (area_ofs_in[IDX_MSB:IDX_LSB] == WIN_OFS[IDX_MSB:IDX_LSB]);

endmodule

// ===== testbench/host_bus_model.sv
// behavioural host bus: address, strobes and board option
`timescale 1ns/1ps
module host_bus_model
  import io_select_pkg::*;
(
  input  wire logic clk_in,
  output host_bus_t bus_out,
  output logic      opt_out
);
  // idle bus at time zero, both strobes high
  initial bus_out = '{16'h0000, 1'b1, 1'b1};
  initial opt_out = 1'b0;
  // changes land just after an edge so every sample is settled
  task automatic drive(input host_bus_t v, input logic q);
    @(posedge clk_in) #2;
    bus_out = v;
    opt_out = q;
  endtask
endmodule

// ===== testbench/io_select_checker_assertions.sv
// checker for the chip-select decoder ports
`timescale 1ns/1ps
module io_select_checker
  import io_select_pkg::*;
(
  // host side
  input wire logic CLK_IN, RST_IN, RD_N_IN, WR_N_IN, STROBE_QUALIFY_OPTION_IN,
  input wire logic [15:0] ADDR_IN,
  // selects
  input wire logic CLOCK_CHIP_SELECT_N_OUT, CAN_CHIP_SELECT_N_OUT, DISPLAY_CHIP_SELECT_N_OUT,
  input wire logic USER_SELECT4_N_OUT, USER_SELECT8_N_OUT, SELECT_ACTIVE_OUT
);
  // decode the selects follow one edge later
  wire logic area = ADDR_IN[15:9] == IO_BASE[15:9];
  wire logic gate = STROBE_QUALIFY_OPTION_IN && RD_N_IN && WR_N_IN;
  wire logic hit = area && !gate;
  wire logic [2:0] ix = ADDR_IN[8:6];
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  a_clock_win: assert property (hit && ix == 0 |=> !CLOCK_CHIP_SELECT_N_OUT)
    else $error("clock select");
  a_can_win: assert property (hit && ix == 1 |=> !CAN_CHIP_SELECT_N_OUT)
    else $error("can select");
  a_disp_win: assert property (hit && ix == 2 |=> !DISPLAY_CHIP_SELECT_N_OUT)
    else $error("display select");
  a_user_four: assert property (hit && ix == 3 |=> !USER_SELECT4_N_OUT)
    else $error("user4 select");
  a_user_eight: assert property (hit && ix == 7 |=> !USER_SELECT8_N_OUT)
    else $error("user8 select");
  a_addr_only: assert property (area && !STROBE_QUALIFY_OPTION_IN |=> SELECT_ACTIVE_OUT)
    else $error("address only");
  a_strobe_gate: assert property (gate |=> !SELECT_ACTIVE_OUT)
    else $error("strobe gate");
  a_outside_idle: assert property (!area |=> !SELECT_ACTIVE_OUT)
    else $error("outside area");
  c_user8: cover property (hit && ix == 7);
  c_gated: cover property (area && gate);
  c_read: cover property (hit && STROBE_QUALIFY_OPTION_IN);
endmodule
bind io_window_chip_select_decoder io_select_checker i_io_select_checker (.*);

// ===== testbench/testbench.sv
// self-checking bench for the chip-select decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module testbench
  import io_select_pkg::*;
;
  logic clk = 0, rst = 1, opt;
  host_bus_t bus, b;
  wire logic [8:0] seen;
  int errors = 0, check_count = 0;
  host_bus_model i_host_bus_model (.clk_in(clk), .bus_out(bus), .opt_out(opt));
  io_window_chip_select_decoder i_io_window_chip_select_decoder (.CLK_IN(clk), .RST_IN(rst),
    .ADDR_IN(bus.addr), .RD_N_IN(bus.rd_n), .WR_N_IN(bus.wr_n), .STROBE_QUALIFY_OPTION_IN(opt),
    .CLOCK_CHIP_SELECT_N_OUT(seen[0]), .CAN_CHIP_SELECT_N_OUT(seen[1]),
    .DISPLAY_CHIP_SELECT_N_OUT(seen[2]), .USER_SELECT4_N_OUT(seen[3]),
    .USER_SELECT5_N_OUT(seen[4]), .USER_SELECT6_N_OUT(seen[5]),
    .USER_SELECT7_N_OUT(seen[6]), .USER_SELECT8_N_OUT(seen[7]), .SELECT_ACTIVE_OUT(seen[8]));
  initial forever #12.5 clk = ~clk;
  // one low select inside the area unless idle strobes gate it
  function automatic logic [8:0] want(input host_bus_t v, input logic q);
    if (v.addr[15:9] != IO_BASE[15:9] || (q && v.rd_n && v.wr_n)) return {1'b0, SEL_IDLE};
    return {1'b1, ~(8'h01 << v.addr[8:6])};
  endfunction
  // answer is due exactly one edge after the sample
  task automatic step(input logic q);
    i_host_bus_model.drive(b, q);
    @(posedge clk) #1;
    `CHK("selects", want(b, q), seen)
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hE3F91F8C));
    repeat (3) @(posedge clk);
    #2;
    `CHK("reset", {1'b0, SEL_IDLE}, seen)
    rst = 0;
    // top edge of each window, plus F9FF below the area and FC3F above it, in all four strobe modes
    for (int k = 0; k < 10; k++)
      for (int m = 0; m < 4; m++)
      begin
        b = '{16'hF9FF + 16'(k * 64), m != 2, m != 3};
        step(m > 0);
      end
    $display("edge test done");
    // half the addresses fall in the area; strobes never both low
    repeat (400)
    begin
      b.addr = {IO_BASE[15:10], 10'($urandom)};
      b.rd_n = 1'($urandom);
      b.wr_n = !b.rd_n || 1'($urandom);
      step(1'($urandom));
    end
    $display("random test done");
    conclude;
  end
endmodule
